// File: qsf_cmd_defines.vh
// Register map and field encodings
`ifndef QSF_CMD_DEFINES_VH
`define QSF_CMD_DEFINES_VH
`define ADDR_MODE_CTRL 32'h0c000004
`define ADDR_READ_RESULT 32'h0c000008
`define ADDR_CMD_FIRST 32'h0c00000c
`define ADDR_CMD_SECOND 32'h0c000010
`define ADDR_STATUS 32'h0c000014
`define ADDR_MREAD_START 32'h0c000030
`define CTRL_WRITABLE 32'h00000057
`define SECOND_WRITABLE 32'h0000ffff
`define RESET_WORD 32'h00000000
`define CTL_MODE 0
`define CTL_POL 1
`define CTL_WP_OE 2
`define CTL_WP_VAL 4
`define CTL_NOSTALL 6
`define A_DMY_W 31:30
`define A_EXT_W 29:28
`define A_ADR_W 27:26
`define A_INS_W 25:24
`define A_EXT_VAL 23:16
`define A_WRAP_OP 15:8
`define A_LIN_OP 7:0
`define B_DMY_FORCE 15
`define B_IDLE_MIN 14:12
`define B_WRAP_SIZE 11:10
`define B_WRAP_LEN 9:8
`define B_WRAP_SEL 7
`define B_OP_ONCE 6
`define B_DMY_NUM 5:4
`define B_NIB_TRI 3
`define B_EXT_EN 2
`define B_DAT_W 1:0
`define W_SINGLE 2'h0
`define W_DUAL 2'h1
`define W_QUAD 2'h2
`define W_RSVD 2'h3
`define DMY_NONE 2'h0
`define DMY_ONE 2'h1
`define DMY_TWO 2'h2
`define DMY_FORCED_BYTES 3'h3
`define DMY_MAX_BYTES 3'h4
`define PH_INST 3'h0
`define PH_ADDR 3'h1
`define PH_EXT 3'h2
`define PH_DUMMY 3'h3
`define PH_DATA 3'h4
`define INST_BYTES 3'h1
`define ADDR_BYTES 3'h3
`define EXT_BYTES 3'h1
`define DATA_BYTES 3'h4
`define NIBBLE_BITS 6'h4
`define SCK_HALF_CYCLES 6'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: qsf_sync_two_ff.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module qsf_sync_two_ff #(
   parameter WIDTH = 4
) (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Asynchronous in, synchronous out
   input wire [WIDTH-1:0] async_i,
   output reg [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] stage;
   always @(posedge clock_i) begin
      if (reset_i) begin
         stage <= {WIDTH{1'b0}};
         sync_o <= {WIDTH{1'b0}};
      end else begin
         stage <= async_i;
         sync_o <= stage;
      end
   end
endmodule
`default_nettype wire

// File: qsf_sck_gen.v
// Serial clock divider
`timescale 1ns/100ps
`default_nettype none
`include "qsf_cmd_defines.vh"
module qsf_sck_gen (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // Control
   input wire run_i,
   input wire polarity_i,
   // Serial clock and edges
   output reg sck_o,
   output reg rise_o,
   output reg fall_o,
   output wire idle_o
);
   reg [5:0] cnt;
   reg act;
   assign idle_o = ~act;
   always @(posedge clock_i) begin
      if (reset_i) begin
         sck_o <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
         cnt <= 6'h0;
         act <= 1'b0;
      end else begin
         rise_o <= 1'b0;
         fall_o <= 1'b0;
         if (!run_i && (!act || sck_o == polarity_i)) begin
            // Park at the idle level
            sck_o <= polarity_i;
            act <= 1'b0;
            cnt <= 6'h0;
         end else begin
            act <= 1'b1;
            if (cnt == `SCK_HALF_CYCLES - 6'h1) begin
               cnt <= 6'h0;
               sck_o <= ~sck_o;
               rise_o <= ~sck_o;
               fall_o <= sck_o;
            end else begin
               cnt <= cnt + 6'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: quad_serial_flash_cmd_config.v
// Serial flash command block
`timescale 1ns/100ps
`default_nettype none
`include "qsf_cmd_defines.vh"
// Behaviour
// [RULE_01] Write-protect pad drives when its enable is 1.
// [RULE_02] Software clears that enable in auto quad use.
// [RULE_03] Polarity sets the idle serial clock level.
// [RULE_04] Mode bit: 0 manual, 1 auto.
// [RULE_05] Mode bit ignores writes during erase.
// [RULE_06] Read result holds the last manual read word.
// [RULE_07] Phase widths: 00 single, 01 dual, 10 quad.
// [RULE_08] Data width field picks the lanes.
// [RULE_09] Extra byte follows the address when enabled.
// [RULE_10] Half-disable tristates the extra low nibble.
// [RULE_11] Matching wraps use the wrap opcode, else linear.
// [RULE_12] Wrap size: byte, half, word.
// [RULE_13] Wrap length: 4, 8, 16 beats.
// [RULE_14] Wrap select only with a flash wrap opcode.
// [RULE_15] Opcode-once sends the opcode on first auto access.
// [RULE_16] Dummy count: 0, 1, 2 or 4 bytes.
// [RULE_17] Dummy force gives three bytes.
// [RULE_18] Chip select idles high for the minimum cycles.
// [RULE_19] Driven write-protect pad carries its value bit.
// [RULE_20] Transfer-active flag is 1 during manual transfers.
// [RULE_21] Auto order: opcode, address, extra, dummy, data.
module quad_serial_flash_cmd_config (
   // Clock and reset
   input wire clock_i,
   input wire reset_i,
   // AXI4-Lite write channels
   input wire [31:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   output reg [1:0] s_axi_bresp_o,
   output reg s_axi_bvalid_o,
   input wire s_axi_bready_i,
   // AXI4-Lite read channels
   input wire [31:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   output reg [31:0] s_axi_rdata_o,
   output reg [1:0] s_axi_rresp_o,
   output reg s_axi_rvalid_o,
   input wire s_axi_rready_i,
   // Auto mode read requests
   input wire auto_req_valid_i,
   output wire auto_req_ready_o,
   input wire [23:0] auto_addr_i,
   input wire auto_wrap_i,
   input wire [1:0] auto_wrap_len_i,
   input wire [1:0] auto_wrap_size_i,
   output reg [31:0] auto_rdata_o,
   output reg auto_rvalid_o,
   // Erase engine status
   input wire erase_active_i,
   // Flash pins
   output wire sck_o,
   output reg cs_n_o,
   output wire [3:0] io_out_o,
   output wire [3:0] io_oe_n_o,
   input wire [3:0] io_in_i
);
   localparam S_IDLE = 2'h0;
   localparam S_LOAD = 2'h1;
   localparam S_SHIFT = 2'h2;
   localparam S_STOP = 2'h3;

   function [1:0] lane_shift;
      input [1:0] w;
      begin
         case (w)
            `W_DUAL: lane_shift = 2'h1;
            `W_QUAD: lane_shift = 2'h2;
            default: lane_shift = 2'h0;
         endcase
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] s;
      reg [31:0] m;
      begin
         m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
         merge = (old & ~m) | (nw & m);
      end
   endfunction

   reg [31:0] ctrl;
   reg [31:0] cmd_a;
   reg [31:0] cmd_b;
   reg [31:0] mread;
   reg mbusy;
   reg aw_hold;
   reg w_hold;
   reg [31:0] waddr;
   reg [31:0] wdata;
   reg [3:0] wstrb;
   reg [1:0] state;
   reg [2:0] phase;
   reg [5:0] cnt;
   reg [31:0] tx;
   reg [31:0] rx;
   reg [1:0] cur_w;
   reg drv;
   reg risen;
   reg end_pend;
   reg is_man;
   reg run;
   reg inst_done;
   reg [5:0] gap;
   reg [23:0] addr;
   reg [7:0] op;
   wire [3:0] io_s;
   wire rise_p;
   wire fall_p;
   wire gen_idle;

   qsf_sync_two_ff #(.WIDTH(4)) u_sync (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .async_i(io_in_i),
      .sync_o(io_s)
   );

   qsf_sck_gen u_sck (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .run_i(run),
      .polarity_i(ctrl[`CTL_POL]), // RULE_03
      .sck_o(sck_o),
      .rise_o(rise_p),
      .fall_o(fall_p),
      .idle_o(gen_idle)
   );

   // Register bus
   wire do_write = aw_hold && w_hold && !s_axi_bvalid_o;
   assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
   assign s_axi_wready_o = !w_hold && !s_axi_bvalid_o;
   assign s_axi_arready_o = !s_axi_rvalid_o;
   wire [31:0] wr_merged_ctrl = merge(ctrl, wdata, wstrb) & `CTRL_WRITABLE;

   always @(posedge clock_i) begin
      if (reset_i) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         waddr <= `RESET_WORD;
         wdata <= `RESET_WORD;
         wstrb <= 4'h0;
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= `RESP_OKAY;
         ctrl <= `RESET_WORD;
         cmd_a <= `RESET_WORD;
         cmd_b <= `RESET_WORD;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold <= 1'b1;
            waddr <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold <= 1'b1;
            wdata <= s_axi_wdata_i;
            wstrb <= s_axi_wstrb_i;
         end
         if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
         if (do_write) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= `RESP_OKAY;
            case (waddr)
               `ADDR_MODE_CTRL: begin
                  ctrl <= wr_merged_ctrl;
                  if (erase_active_i) begin
                     ctrl[`CTL_MODE] <= ctrl[`CTL_MODE]; // RULE_05
                  end
               end
               `ADDR_CMD_FIRST: cmd_a <= merge(cmd_a, wdata, wstrb);
               `ADDR_CMD_SECOND: cmd_b <= merge(cmd_b, wdata, wstrb) & `SECOND_WRITABLE;
               `ADDR_READ_RESULT, `ADDR_STATUS, `ADDR_MREAD_START: begin
               end
               default: s_axi_bresp_o <= `RESP_SLVERR;
            endcase
         end
      end
   end

   always @(posedge clock_i) begin
      if (reset_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= `RESET_WORD;
         s_axi_rresp_o <= `RESP_OKAY;
      end else begin
         if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
         if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= `RESP_OKAY;
            case (s_axi_araddr_i)
               `ADDR_MODE_CTRL: s_axi_rdata_o <= ctrl;
               `ADDR_READ_RESULT: s_axi_rdata_o <= mread; // RULE_06
               `ADDR_CMD_FIRST: s_axi_rdata_o <= cmd_a;
               `ADDR_CMD_SECOND: s_axi_rdata_o <= cmd_b;
               `ADDR_STATUS: s_axi_rdata_o <= {31'h0, mbusy}; // RULE_20
               `ADDR_MREAD_START: s_axi_rdata_o <= `RESET_WORD;
               default: begin
                  s_axi_rdata_o <= `RESET_WORD;
                  s_axi_rresp_o <= `RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // Command selection
   reg [2:0] dmy_bytes;
   always @* begin
      case (cmd_b[`B_DMY_NUM]) // RULE_16
         `DMY_NONE: dmy_bytes = 3'h0;
         `DMY_ONE: dmy_bytes = 3'h1;
         `DMY_TWO: dmy_bytes = 3'h2;
         default: dmy_bytes = `DMY_MAX_BYTES;
      endcase
      if (cmd_b[`B_DMY_FORCE]) begin
         dmy_bytes = `DMY_FORCED_BYTES; // RULE_17
      end
   end

   wire wrap_hit = cmd_b[`B_WRAP_SEL] && auto_wrap_i // RULE_11
      && auto_wrap_len_i == cmd_b[`B_WRAP_LEN] && cmd_b[`B_WRAP_LEN] != `W_RSVD // RULE_13
      && auto_wrap_size_i == cmd_b[`B_WRAP_SIZE] && cmd_b[`B_WRAP_SIZE] != `W_RSVD; // RULE_12
   wire skip_inst = cmd_b[`B_OP_ONCE] && inst_done; // RULE_15
   assign auto_req_ready_o = (state == S_IDLE) && ctrl[`CTL_MODE] && (gap == 6'h0); // RULE_04
   wire auto_take = auto_req_valid_i && auto_req_ready_o;
   wire man_start = do_write && waddr == `ADDR_MREAD_START && !ctrl[`CTL_MODE]
      && state == S_IDLE && gap == 6'h0;

   reg [2:0] nxt_ph;
   always @* begin
      case (phase) // RULE_21
         `PH_INST: nxt_ph = `PH_ADDR;
         `PH_ADDR: nxt_ph = cmd_b[`B_EXT_EN] ? `PH_EXT : // RULE_09
            (dmy_bytes != 3'h0 ? `PH_DUMMY : `PH_DATA);
         `PH_EXT: nxt_ph = dmy_bytes != 3'h0 ? `PH_DUMMY : `PH_DATA;
         default: nxt_ph = `PH_DATA;
      endcase
   end

   reg [2:0] ld_ph;
   reg [31:0] ld_tx;
   reg [1:0] ld_w;
   reg [2:0] ld_bytes;
   reg ld_drv;
   always @* begin
      ld_ph = (state == S_LOAD) ? phase : nxt_ph;
      ld_tx = `RESET_WORD;
      ld_drv = 1'b0;
      case (ld_ph) // RULE_07
         `PH_INST: begin
            ld_tx = {op, 24'h0};
            ld_w = cmd_a[`A_INS_W];
            ld_bytes = `INST_BYTES;
            ld_drv = 1'b1;
         end
         `PH_ADDR: begin
            ld_tx = {addr, 8'h0};
            ld_w = cmd_a[`A_ADR_W];
            ld_bytes = `ADDR_BYTES;
            ld_drv = 1'b1;
         end
         `PH_EXT: begin
            ld_tx = {cmd_a[`A_EXT_VAL], 24'h0};
            ld_w = cmd_a[`A_EXT_W];
            ld_bytes = `EXT_BYTES;
            ld_drv = 1'b1;
         end
         `PH_DUMMY: begin
            ld_w = cmd_a[`A_DMY_W];
            ld_bytes = dmy_bytes;
         end
         default: begin
            ld_w = cmd_b[`B_DAT_W]; // RULE_08
            ld_bytes = `DATA_BYTES;
         end
      endcase
   end
   wire [5:0] ld_cnt = {ld_bytes, 3'h0} >> lane_shift(ld_w);

   reg [31:0] rx_next;
   reg [31:0] tx_next;
   reg [3:0] lane_out;
   reg [3:0] lane_mask;
   always @* begin
      case (cur_w)
         `W_DUAL: begin
            rx_next = {rx[29:0], io_s[1:0]};
            tx_next = {tx[29:0], 2'h0};
            lane_out = {2'h0, tx[31:30]};
            lane_mask = 4'h3;
         end
         `W_QUAD: begin
            rx_next = {rx[27:0], io_s};
            tx_next = {tx[27:0], 4'h0};
            lane_out = tx[31:28];
            lane_mask = 4'hf;
         end
         default: begin
            rx_next = {rx[30:0], io_s[1]};
            tx_next = {tx[30:0], 1'h0};
            lane_out = {3'h0, tx[31]};
            lane_mask = 4'h1;
         end
      endcase
   end

   wire nib_off = phase == `PH_EXT && cmd_b[`B_NIB_TRI]
      && cnt <= (`NIBBLE_BITS >> lane_shift(cur_w)); // RULE_10
   wire [3:0] eng_oe = (drv && !nib_off) ? lane_mask : 4'h0;
   wire wp_oe = ctrl[`CTL_WP_OE] && !eng_oe[2]; // RULE_01
   assign io_out_o = {lane_out[3], eng_oe[2] ? lane_out[2] : ctrl[`CTL_WP_VAL], // RULE_19
      lane_out[1:0]};
   assign io_oe_n_o = ~(eng_oe | {1'b0, wp_oe, 2'h0});

   wire do_load = (state == S_LOAD) || (state == S_SHIFT && fall_p && risen && end_pend);

   // Transfer sequencer
   always @(posedge clock_i) begin
      if (reset_i) begin
         state <= S_IDLE;
         phase <= `PH_INST;
         cnt <= 6'h0;
         tx <= `RESET_WORD;
         rx <= `RESET_WORD;
         cur_w <= `W_SINGLE;
         drv <= 1'b0;
         risen <= 1'b0;
         end_pend <= 1'b0;
         is_man <= 1'b0;
         run <= 1'b0;
         inst_done <= 1'b0;
         gap <= 6'h0;
         addr <= 24'h0;
         op <= 8'h0;
         cs_n_o <= 1'b1;
         mbusy <= 1'b0;
         mread <= `RESET_WORD;
         auto_rdata_o <= `RESET_WORD;
         auto_rvalid_o <= 1'b0;
      end else begin
         auto_rvalid_o <= 1'b0;
         if (!ctrl[`CTL_MODE]) begin
            inst_done <= 1'b0; // RULE_15
         end
         if (do_load) begin
            tx <= ld_tx;
            cur_w <= ld_w;
            cnt <= ld_cnt;
            drv <= ld_drv;
            phase <= ld_ph;
            risen <= 1'b0;
            end_pend <= 1'b0;
            if (ld_ph == `PH_INST) begin
               inst_done <= 1'b1;
            end
         end
         case (state)
            S_IDLE: begin
               if (gap != 6'h0) begin
                  gap <= gap - 6'h1; // RULE_18
               end
               if (auto_take) begin
                  addr <= auto_addr_i;
                  op <= wrap_hit ? cmd_a[`A_WRAP_OP] : cmd_a[`A_LIN_OP];
                  phase <= skip_inst ? `PH_ADDR : `PH_INST;
                  is_man <= 1'b0;
                  state <= S_LOAD;
               end else if (man_start) begin
                  phase <= `PH_DATA;
                  is_man <= 1'b1;
                  mbusy <= 1'b1; // RULE_20
                  state <= S_LOAD;
               end
            end
            S_LOAD: begin
               cs_n_o <= 1'b0;
               run <= 1'b1;
               state <= S_SHIFT;
            end
            S_SHIFT: begin
               if (rise_p) begin
                  rx <= rx_next;
                  risen <= 1'b1;
                  cnt <= cnt - 6'h1;
                  if (cnt == 6'h1) begin
                     if (phase == `PH_DATA) begin
                        run <= 1'b0;
                        state <= S_STOP;
                        if (is_man) begin
                           mread <= rx_next; // RULE_06
                        end else begin
                           auto_rdata_o <= rx_next;
                           auto_rvalid_o <= 1'b1;
                        end
                     end else begin
                        end_pend <= 1'b1;
                     end
                  end
               end else if (fall_p && risen && !end_pend) begin
                  tx <= tx_next;
               end
            end
            default: begin
               drv <= 1'b0;
               if (gen_idle) begin
                  cs_n_o <= 1'b1;
                  gap <= {3'h0, cmd_b[`B_IDLE_MIN]} * (`SCK_HALF_CYCLES + `SCK_HALF_CYCLES); // RULE_18
                  mbusy <= 1'b0;
                  state <= S_IDLE;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// File: qsf_flash_model.sv
// Serial flash model
`timescale 1ns/100ps
`default_nettype none
module qsf_flash_model (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Pins
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic [3:0] io_out_i,
   input wire logic [3:0] io_oe_n_i,
   output logic [3:0] io_in_o,
   // Last frame
   output logic [7:0] rises_o,
   output logic [7:0] hz_o,
   output logic [7:0] opcode_o,
   output logic [15:0] gap_o
);
   logic sck_q, cs_q;
   logic [15:0] high_cnt;
   // Flash answers 4'h6 on all lanes whenever selected; deselected it shows the inverse
   assign io_in_o = cs_n_i ? 4'h9 : 4'h6;
   always @(posedge clock_i) begin
      sck_q <= sck_i;
      cs_q <= cs_n_i;
      if (reset_i) begin
         rises_o <= 8'h00;
         hz_o <= 8'h00;
         opcode_o <= 8'h00;
         gap_o <= 16'h0000;
         high_cnt <= 16'h0000;
      end else if (cs_n_i) begin
         high_cnt <= high_cnt + 16'h0001;
      end else if (cs_q) begin
         rises_o <= 8'h00;
         hz_o <= 8'h00;
         gap_o <= high_cnt;
         high_cnt <= 16'h0000;
      end else if (sck_i && !sck_q) begin
         rises_o <= rises_o + 8'h01;
         if (io_oe_n_i == 4'hf) hz_o <= hz_o + 8'h01;
         if (rises_o < 8'h08) opcode_o <= {opcode_o[6:0], io_out_i[0]};
      end
   end
endmodule
`default_nettype wire

// File: quad_serial_flash_cmd_config_assertions.sv
// Port-level checks of the flash controller
`timescale 1ns/100ps
`default_nettype none
module qsf_cmd_checker (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // Register bus
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Auto reads and pins
   input wire logic auto_req_valid_i,
   input wire logic auto_req_ready_o,
   input wire logic [31:0] auto_rdata_o,
   input wire logic auto_rvalid_o,
   input wire logic sck_o,
   input wire logic cs_n_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (reset_i);
   sequence s_take;
      auto_req_valid_i && auto_req_ready_o;
   endsequence
   sequence s_open;
      !auto_req_ready_o ##1 !cs_n_o;
   endsequence
   property p_auto_take;
      s_take |=> s_open;
   endproperty
   a_auto_take: assert property (p_auto_take) else $error("no frame");
   property p_sel_busy;
      !cs_n_o |-> !auto_req_ready_o;
   endproperty
   a_sel_busy: assert property (p_sel_busy) else $error("ready while selected");
   property p_sck_rate;
      !cs_n_o && $changed(sck_o) |=> $stable(sck_o);
   endproperty
   a_sck_rate: assert property (p_sck_rate) else $error("sck fast");
   property p_apulse;
      auto_rvalid_o |=> !auto_rvalid_o;
   endproperty
   a_apulse: assert property (p_apulse) else $error("long rvalid pulse");
   property p_ahold;
      !auto_rvalid_o |-> $stable(auto_rdata_o);
   endproperty
   a_ahold: assert property (p_ahold) else $error("word moved");
   property p_bhold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped");
   property p_rhold;
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_rhold: assert property (p_rhold) else $error("rvalid dropped");
   property p_wblock;
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
   endproperty
   a_wblock: assert property (p_wblock) else $error("write while answering");
   property p_rblock;
      s_axi_rvalid_o |-> !s_axi_arready_o;
   endproperty
   a_rblock: assert property (p_rblock) else $error("read while answering");
endmodule
bind quad_serial_flash_cmd_config qsf_cmd_checker i_chk (.*);
`default_nettype wire

// File: tb.sv
// Flash command block bench
`timescale 1ns/100ps
`default_nettype none
`include "qsf_cmd_defines.vh"
module tb;
   logic clock_i = 1'b0, reset_i = 1'b1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, auto_rdata, v;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, auto_ready, auto_rvalid, sck, cs_n;
   logic auto_valid = 1'b0, auto_wrap = 1'b0, erase = 1'b0;
   logic [1:0] bresp, rresp, r, auto_len = 2'h0, auto_size = 2'h0;
   logic [3:0] wstrb = 4'hf, io_out, io_oe_n, io_in;
   logic [23:0] auto_addr = 24'h0;
   logic [7:0] rises, hz, opcode;
   logic [15:0] gap;
   int errors = 0, n_tests = 0;
   always #2 clock_i = ~clock_i;
   quad_serial_flash_cmd_config i_dut (.clock_i(clock_i), .reset_i(reset_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .auto_req_valid_i(auto_valid),
      .auto_req_ready_o(auto_ready), .auto_addr_i(auto_addr), .auto_wrap_i(auto_wrap),
      .auto_wrap_len_i(auto_len), .auto_wrap_size_i(auto_size), .auto_rdata_o(auto_rdata),
      .auto_rvalid_o(auto_rvalid), .erase_active_i(erase), .sck_o(sck), .cs_n_o(cs_n),
      .io_out_o(io_out), .io_oe_n_o(io_oe_n), .io_in_i(io_in));
   qsf_flash_model i_flash (.clock_i(clock_i), .reset_i(reset_i), .sck_i(sck), .cs_n_i(cs_n),
      .io_out_i(io_out), .io_oe_n_i(io_oe_n), .io_in_o(io_in), .rises_o(rises), .hz_o(hz),
      .opcode_o(opcode), .gap_o(gap));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic aw_done = 1'b0, w_done = 1'b0;
      @(posedge clock_i);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clock_i);
         aw_done |= awvalid && awready;
         w_done |= wvalid && wready;
         @(posedge clock_i);
         awvalid <= !aw_done;
         wvalid <= !w_done;
      end while (!(aw_done && w_done));
      do @(negedge clock_i); while (!bvalid);
      r = bresp;
      @(posedge clock_i);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      @(posedge clock_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clock_i); while (!arready);
      @(posedge clock_i);
      arvalid <= 1'b0;
      do @(negedge clock_i); while (!rvalid);
      v = rdata;
      r = rresp;
      @(posedge clock_i);
      rready <= 1'b0;
   endtask
   // One auto read, word left in v
   task automatic ard(input logic w, input logic [1:0] len, input logic [1:0] size);
      @(posedge clock_i);
      auto_valid <= 1'b1;
      auto_wrap <= w;
      auto_len <= len;
      auto_size <= size;
      auto_addr <= auto_addr + 24'h000104;
      do @(negedge clock_i); while (!auto_ready);
      @(posedge clock_i);
      auto_valid <= 1'b0;
      do @(negedge clock_i); while (!auto_rvalid);
      v = auto_rdata;
      do @(negedge clock_i); while (!cs_n);
   endtask
   task automatic t_regs;
      for (int i = 0; i < 4; i++) begin
         rd(`ADDR_MODE_CTRL + 32'h4 * i);
         chk(v, 32'h0);
      end
      wr(`ADDR_MODE_CTRL, 32'hffffffff);
      rd(`ADDR_MODE_CTRL);
      chk(v, 32'h00000057);
      wr(`ADDR_CMD_FIRST, 32'hffffffff);
      rd(`ADDR_CMD_FIRST);
      chk(v, 32'hffffffff);
      wr(`ADDR_CMD_SECOND, 32'hffffffff);
      rd(`ADDR_CMD_SECOND);
      chk(v, 32'h0000ffff);
      wr(`ADDR_READ_RESULT, 32'h12345678);
      rd(`ADDR_READ_RESULT);
      chk({r, v}, {`RESP_OKAY, 32'h0});
      wr(32'h0c000100, 32'h1);
      chk(r, `RESP_SLVERR);
      rd(32'h0c000100);
      chk({r, v}, {`RESP_SLVERR, 32'h0});
   endtask
   task automatic t_pins;
      wr(`ADDR_MODE_CTRL, 32'h00000016);
      @(negedge clock_i);
      chk({sck, io_oe_n[2], io_out[2]}, 3'h5);
      wr(`ADDR_MODE_CTRL, 32'h00000004);
      @(negedge clock_i);
      chk({sck, io_oe_n[2], io_out[2]}, 3'h0);
      wr(`ADDR_MODE_CTRL, 32'h00000000);
      chk(io_oe_n[2], 1'b1);
   endtask
   task automatic t_erase;
      erase <= 1'b1;
      wr(`ADDR_MODE_CTRL, 32'h1);
      rd(`ADDR_MODE_CTRL);
      chk({v, auto_ready}, 33'h0);
      erase <= 1'b0;
      wr(`ADDR_MODE_CTRL, 32'h1);
      rd(`ADDR_MODE_CTRL);
      chk({v, auto_ready}, 33'h3);
   endtask
   task automatic t_dummy;
      int nb[5] = '{0, 1, 2, 4, 3};
      wr(`ADDR_CMD_FIRST, 32'h0000003a);
      for (int i = 0; i < 5; i++) begin
         wr(`ADDR_CMD_SECOND, (i == 4) ? 32'h8030 : 32'(i) << 4);
         ard(1'b0, 2'h0, 2'h0);
         chk(rises, 64 + 8 * nb[i]);
         chk({v, opcode}, {32'hffffffff, 8'h3a});
      end
   endtask
   task automatic t_wrap;
      // Wrap opcode set before wrap select
      wr(`ADDR_CMD_FIRST, 32'h0000c33a);
      for (int k = 0; k < 3; k++) begin
         wr(`ADDR_CMD_SECOND, 32'h80 | (32'(k) << 8) | (32'(k) << 10));
         ard(1'b1, 2'(k), 2'(k));
         chk(opcode, 8'hc3);
         ard(1'b1, 2'(k), (k == 2) ? 2'h0 : 2'(k + 1));
         chk(opcode, 8'h3a);
      end
      ard(1'b0, 2'h2, 2'h2);
      chk(opcode, 8'h3a);
      wr(`ADDR_CMD_SECOND, 32'h00000a00);
      ard(1'b1, 2'h2, 2'h2);
      chk(opcode, 8'h3a);
   endtask
   task automatic t_once;
      wr(`ADDR_CMD_SECOND, 32'h40);
      for (int i = 0; i < 2; i++) begin
         wr(`ADDR_MODE_CTRL, 32'h0);
         wr(`ADDR_MODE_CTRL, 32'h1);
         ard(1'b0, 2'h0, 2'h0);
         chk(rises, 64);
         ard(1'b0, 2'h0, 2'h0);
         chk(rises, 56);
      end
   endtask
   task automatic t_gap;
      wr(`ADDR_CMD_SECOND, 32'h7000);
      ard(1'b0, 2'h0, 2'h0);
      ard(1'b0, 2'h0, 2'h0);
      chk(gap >= 16'h001c, 1'b1);
   endtask
   task automatic t_quad;
      // Write-protect drive clear for quad
      wr(`ADDR_MODE_CTRL, 32'h1);
      wr(`ADDR_CMD_FIRST, 32'haa5c003a);
      wr(`ADDR_CMD_SECOND, 32'h6);
      ard(1'b0, 2'h0, 2'h0);
      chk({rises, hz, v}, {8'h12, 8'h08, 32'h66666666});
      wr(`ADDR_CMD_SECOND, 32'he);
      ard(1'b0, 2'h0, 2'h0);
      chk({rises, hz}, {8'h12, 8'h09});
      wr(`ADDR_CMD_FIRST, 32'h5500003a);
      wr(`ADDR_CMD_SECOND, 32'h1);
      ard(1'b0, 2'h0, 2'h0);
      chk({rises, v}, {8'h20, 32'haaaaaaaa});
   endtask
   task automatic t_manual;
      wr(`ADDR_CMD_SECOND, 32'h0);
      wr(`ADDR_MODE_CTRL, 32'h40);
      wr(`ADDR_MREAD_START, 32'h0);
      rd(`ADDR_STATUS);
      chk(v, 32'h1);
      for (int i = 0; i < 60 && v[0]; i++) rd(`ADDR_STATUS);
      chk(v, 32'h0);
      rd(`ADDR_READ_RESULT);
      chk(v, 32'hffffffff);
   endtask
   task automatic test_done;
      $display("Checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clock_i);
      reset_i <= 1'b0;
      t_regs();
      t_pins();
      t_erase();
      t_dummy();
      t_wrap();
      t_once();
      t_gap();
      t_quad();
      t_manual();
      test_done();
   end
   initial begin
      #200000;
      errors++;
      test_done();
   end
endmodule
`default_nettype wire
